/* sdc_pkg.sv */
// package for the dual-element simd core datapath
// assumes one core clock and no software-visible register bus
package sdc_pkg;
    localparam int DATA_W      = 40;
    localparam int WORD_W      = 32;
    localparam int BUS_W       = 64;
    localparam int INSTR_W     = 48;
    localparam int REG_CNT     = 16;
    localparam int REG_AW      = 4;
    localparam int UNIV_CNT    = 4;
    localparam int UNIV_AW     = 2;
    localparam int CACHE_CNT   = 4;
    localparam int CACHE_AW    = 2;
    localparam int TIMER_W     = 32;
    localparam int BIT_PEY_EN  = 0;
    localparam int BIT_SEC_REG = 1;
    localparam int BIT_SEC_MUL = 2;
    localparam int BIT_SEC_ADR = 3;
    localparam int BIT_TMR_FLG = 4;
    localparam int MODE_W      = 5;
    localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        FMT_FIXED, FMT_SINGLE, FMT_EXTENDED
    } sdc_fmt_type;

    typedef enum logic [3:0] {
        OP_NOP, OP_ADD, OP_SUB, OP_MUL, OP_SHL, OP_SHR, OP_MAC, OP_PASS
    } sdc_op_type;

    typedef enum logic [2:0] {
        UB_SET, UB_CLR, UB_TGL, UB_TST, UB_XOR, UB_LOAD
    } sdc_ubit_type;

    typedef enum logic [1:0] {
        PX_NONE, PX_PM_TO_DM, PX_DM_TO_PM, PX_FROM_REG
    } sdc_px_type;
endpackage : sdc_pkg

/* sdc_element.sv */
// one processing element: alu, multiplier, shifter, register file
// assumes operands and opcode are stable for the cycle they are issued
`timescale 1ns/100ps
`default_nettype none
module sdc_element
    import sdc_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // issue
    input  wire logic              enable,
    input  wire logic              secRegSel,
    input  wire logic              secMulSel,
    input  wire sdc_op_type        aluOp,
    input  wire sdc_op_type        mulOp,
    input  wire sdc_fmt_type       fmt,
    input  wire logic [REG_AW-1:0] srcA,
    input  wire logic [REG_AW-1:0] srcB,
    input  wire logic [REG_AW-1:0] dstAlu,
    input  wire logic [REG_AW-1:0] dstMul,
    // memory load ports
    input  wire logic              loadEn0,
    input  wire logic [REG_AW-1:0] loadIdx0,
    input  wire logic [DATA_W-1:0] loadData0,
    input  wire logic              loadEn1,
    input  wire logic [REG_AW-1:0] loadIdx1,
    input  wire logic [DATA_W-1:0] loadData1,
    // store ports
    input  wire logic [REG_AW-1:0] storeIdx0,
    input  wire logic [REG_AW-1:0] storeIdx1,
    output logic      [DATA_W-1:0] storeData0,
    output logic      [DATA_W-1:0] storeData1,
    // status
    output logic      [DATA_W-1:0] mulResult,
    output logic                   zeroFlag
);
    // 32 entries: index bit REG_AW picks primary or secondary half
    logic [DATA_W-1:0] regFile [2*REG_CNT];
    logic [DATA_W-1:0] mulAcc  [2];
    logic [DATA_W-1:0] opA;
    logic [DATA_W-1:0] opB;
    logic [DATA_W-1:0] next_alu;
    logic [DATA_W-1:0] next_mul;
    logic [2*DATA_W-1:0] product;
    logic [REG_AW:0]   bank;

    assign bank = {secRegSel, {REG_AW{1'b0}}};
    assign opA  = regFile[bank + {1'b0, srcA}];
    assign opB  = regFile[bank + {1'b0, srcB}];
    assign product = opA * opB;
    assign storeData0 = regFile[bank + {1'b0, storeIdx0}];
    assign storeData1 = regFile[bank + {1'b0, storeIdx1}];
    assign mulResult  = mulAcc[secMulSel];

    // single-cycle units; fixed and single use the low word, extended all 40 bits
    always_comb
    begin
        next_alu = opA;
        case (aluOp)
            OP_ADD:  next_alu = opA + opB;
            OP_SUB:  next_alu = opA - opB;
            OP_SHL:  next_alu = opA << opB[5:0];
            OP_SHR:  next_alu = opA >> opB[5:0];
            OP_PASS: next_alu = opA;
            default: next_alu = opA;
        endcase
        if (fmt != FMT_EXTENDED)
            next_alu = {{(DATA_W-WORD_W){1'b0}}, next_alu[WORD_W-1:0]};
    end

    always_comb
    begin
        case (mulOp)
            OP_MUL:  next_mul = product[DATA_W-1:0];
            OP_MAC:  next_mul = mulAcc[secMulSel] + product[DATA_W-1:0];
            default: next_mul = mulAcc[secMulSel];
        endcase
        if (fmt != FMT_EXTENDED)
            next_mul[DATA_W-1:WORD_W] = '0;
    end

    // disabled element holds all state
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 2*REG_CNT; i++)
                regFile[i] <= '0;
        end
        else if (enable)
        begin
            if (loadEn0)
                regFile[bank + {1'b0, loadIdx0}] <= loadData0;
            if (loadEn1)
                regFile[bank + {1'b0, loadIdx1}] <= loadData1;
            if (aluOp != OP_NOP)
                regFile[bank + {1'b0, dstAlu}] <= next_alu;
            if (mulOp == OP_MUL || mulOp == OP_MAC)
                regFile[bank + {1'b0, dstMul}] <= next_mul;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mulAcc[0] <= '0;
            mulAcc[1] <= '0;
            zeroFlag  <= 1'b0;
        end
        else if (enable)
        begin
            if (mulOp != OP_NOP)
                mulAcc[secMulSel] <= next_mul;
            if (aluOp != OP_NOP)
                zeroFlag <= (next_alu == '0);
        end
    end
endmodule : sdc_element
`default_nettype wire

/* sdc_core_datapath.sv */
// top of the dual-element simd core datapath
// assumes on-chip memory answers pm and dm reads in the same cycle
//
// Contract
// - The first element always runs and the second only while its enable mode bit is set.
// - In simd mode one instruction drives both elements, each on its own operands.
// - In simd mode each address-generator access moves two values, one per element.
// - Alu, multiplier and shifter finish in one cycle and alu plus multiplier run together.
// - Units accept fixed, single and 40-bit extended formats.
// - The core timer raises periodic interrupts and may drive the flag pin on expiry.
// - Each element has a 32-entry register file, sixteen primary and sixteen secondary.
// - Primary sets are active after reset; secondaries only when mode bits select them.
// - Data, address and multiplier result registers all have secondary copies; no address registers here, only the activeAddrBank select is driven.
// - Four universal registers support set, clear, toggle, test and xor.
// - The exchange register links pm, dm and register file, adapting widths.
// - Pm and dm buses carry two 64-bit transfers every cycle.
// - The dm bus carries data only; the pm bus carries instructions and data.
// - Four operands plus one cached instruction can be fetched in one cycle.
// - Only instructions whose fetch clashed with pm data are cached.
`timescale 1ns/100ps
`default_nettype none
module sdc_core_datapath
    import sdc_pkg::*;
(
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    // mode control
    input  wire logic               modeWrite,
    input  wire logic [MODE_W-1:0]  modeData,
    output logic      [MODE_W-1:0]  primary_mode_control,
    // instruction issue
    input  wire sdc_op_type         aluOp,
    input  wire sdc_op_type         mulOp,
    input  wire sdc_fmt_type        fmt,
    input  wire logic [REG_AW-1:0]  srcA,
    input  wire logic [REG_AW-1:0]  srcB,
    input  wire logic [REG_AW-1:0]  dstAlu,
    input  wire logic [REG_AW-1:0]  dstMul,
    // address generator access
    input  wire logic               dmLoad,
    input  wire logic               pmLoad,
    input  wire logic [REG_AW-1:0]  dmRegIdx,
    input  wire logic [REG_AW-1:0]  pmRegIdx,
    output logic      [REG_AW-1:0]  activeAddrBank,
    // data memory bus, data only
    input  wire logic [BUS_W-1:0]   dmRdData,
    output logic      [BUS_W-1:0]   dmWrData,
    // program memory bus, instructions and data
    input  wire logic [BUS_W-1:0]   pmRdData,
    output logic      [BUS_W-1:0]   pmWrData,
    input  wire logic               fetchReq,
    input  wire logic [CACHE_AW-1:0] fetchTag,
    input  wire logic [INSTR_W-1:0] pmInstr,
    input  wire logic               pmDataBusy,
    output logic                    instrValid,
    output logic      [INSTR_W-1:0] instrOut,
    output logic                    cacheHit,
    // exchange register
    input  wire sdc_px_type         pxOp,
    output logic      [BUS_W-1:0]   bus_exchange_register,
    // universal bit registers
    input  wire logic               ubitEn,
    input  wire sdc_ubit_type       ubitOp,
    input  wire logic [UNIV_AW-1:0] ubitSel,
    input  wire logic [WORD_W-1:0]  ubitMask,
    output logic      [WORD_W-1:0]  ubitValue,
    output logic                    ubitTest,
    // core timer
    input  wire logic               timerLoad,
    input  wire logic [TIMER_W-1:0] timerPeriod,
    input  wire logic               timerRun,
    output logic                    timerIrq,
    output logic                    timer_expired_flag_pin,
    // element status
    output logic      [DATA_W-1:0]  firstMulResult,
    output logic      [DATA_W-1:0]  secondMulResult,
    output logic                    firstZero,
    output logic                    secondZero
);
    logic [DATA_W-1:0]  xStore0;
    logic [DATA_W-1:0]  xStore1;
    logic [DATA_W-1:0]  yStore0;
    logic [DATA_W-1:0]  yStore1;
    logic               simdOn;
    logic [WORD_W-1:0]  universal_bit_registers [UNIV_CNT];
    logic [INSTR_W-1:0] cacheData [CACHE_CNT];
    logic [CACHE_AW-1:0] cacheTagMem [CACHE_CNT];
    logic [CACHE_CNT-1:0] cacheValid;
    logic [CACHE_AW-1:0] cacheSlot;
    logic [TIMER_W-1:0] timerCount;
    logic [TIMER_W-1:0] timerReload;

    assign simdOn = primary_mode_control[BIT_PEY_EN];
    assign activeAddrBank = {{(REG_AW-1){1'b0}}, primary_mode_control[BIT_SEC_ADR]};

    // mode register: zero at reset keeps primary sets and single element
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            primary_mode_control <= MODE_RESET;
        else if (modeWrite)
            primary_mode_control <= modeData;
    end

    // both elements get the same decoded instruction
    // dm feeds first load port, pm the second: two 64-bit moves per cycle
    // in simd the upper word of each bus goes to the second element
    sdc_element firstElement (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .enable     (1'b1),
        .secRegSel  (primary_mode_control[BIT_SEC_REG]),
        .secMulSel  (primary_mode_control[BIT_SEC_MUL]),
        .aluOp      (aluOp),
        .mulOp      (mulOp),
        .fmt        (fmt),
        .srcA       (srcA),
        .srcB       (srcB),
        .dstAlu     (dstAlu),
        .dstMul     (dstMul),
        .loadEn0    (dmLoad),
        .loadIdx0   (dmRegIdx),
        .loadData0  (dmRdData[DATA_W-1:0]),
        .loadEn1    (pmLoad),
        .loadIdx1   (pmRegIdx),
        .loadData1  (pmRdData[DATA_W-1:0]),
        .storeIdx0  (dmRegIdx),
        .storeIdx1  (pmRegIdx),
        .storeData0 (xStore0),
        .storeData1 (xStore1),
        .mulResult  (firstMulResult),
        .zeroFlag   (firstZero)
    );

    sdc_element secondElement (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .enable     (simdOn),
        .secRegSel  (primary_mode_control[BIT_SEC_REG]),
        .secMulSel  (primary_mode_control[BIT_SEC_MUL]),
        .aluOp      (aluOp),
        .mulOp      (mulOp),
        .fmt        (fmt),
        .srcA       (srcA),
        .srcB       (srcB),
        .dstAlu     (dstAlu),
        .dstMul     (dstMul),
        .loadEn0    (dmLoad),
        .loadIdx0   (dmRegIdx),
        .loadData0  ({{(DATA_W-WORD_W){1'b0}}, dmRdData[BUS_W-1:WORD_W]}),
        .loadEn1    (pmLoad),
        .loadIdx1   (pmRegIdx),
        .loadData1  ({{(DATA_W-WORD_W){1'b0}}, pmRdData[BUS_W-1:WORD_W]}),
        .storeIdx0  (dmRegIdx),
        .storeIdx1  (pmRegIdx),
        .storeData0 (yStore0),
        .storeData1 (yStore1),
        .mulResult  (secondMulResult),
        .zeroFlag   (secondZero)
    );

    // store paths pack the second element into the upper word only in simd
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dmWrData <= '0;
            pmWrData <= '0;
        end
        else if (pxOp == PX_NONE)
        begin
            dmWrData <= {simdOn ? yStore0[WORD_W-1:0] : {WORD_W{1'b0}}, xStore0[WORD_W-1:0]};
            pmWrData <= {simdOn ? yStore1[WORD_W-1:0] : {WORD_W{1'b0}}, xStore1[WORD_W-1:0]};
        end
        else if (pxOp == PX_PM_TO_DM)
            dmWrData <= bus_exchange_register;
        else if (pxOp == PX_DM_TO_PM)
            pmWrData <= bus_exchange_register;
    end

    // exchange register: 40-bit file value placed left-justified in 64 bits
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            bus_exchange_register <= '0;
        else if (pxOp == PX_PM_TO_DM)
            bus_exchange_register <= pmRdData;
        else if (pxOp == PX_DM_TO_PM)
            bus_exchange_register <= dmRdData;
        else if (pxOp == PX_FROM_REG)
            bus_exchange_register <= {xStore0, {(BUS_W-DATA_W){1'b0}}};
    end

    // universal bit registers
    assign ubitValue = universal_bit_registers[ubitSel];
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < UNIV_CNT; i++)
                universal_bit_registers[i] <= '0;
            ubitTest <= 1'b0;
        end
        else if (ubitEn)
        begin
            case (ubitOp)
                UB_SET:  universal_bit_registers[ubitSel] <= ubitValue | ubitMask;
                UB_CLR:  universal_bit_registers[ubitSel] <= ubitValue & ~ubitMask;
                UB_TGL:  universal_bit_registers[ubitSel] <= ubitValue ^ ubitMask;
                UB_XOR:  ubitTest <= (ubitValue == ubitMask);
                UB_TST:  ubitTest <= ((ubitValue & ubitMask) == ubitMask);
                UB_LOAD: universal_bit_registers[ubitSel] <= ubitMask;
                default: ubitTest <= ubitTest;
            endcase
        end
    end

    // selective cache: fill only on pm data clash, serve hits
    assign cacheSlot = fetchTag;
    assign cacheHit  = fetchReq && cacheValid[cacheSlot] && cacheTagMem[cacheSlot] == fetchTag;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cacheValid <= '0;
            instrValid <= 1'b0;
            instrOut   <= '0;
            for (int i = 0; i < CACHE_CNT; i++)
            begin
                cacheData[i]   <= '0;
                cacheTagMem[i] <= '0;
            end
        end
        else
        begin
            instrValid <= fetchReq && (cacheHit || !pmDataBusy);
            if (cacheHit)
                instrOut <= cacheData[cacheSlot];
            else if (fetchReq && !pmDataBusy)
                instrOut <= pmInstr;
            if (fetchReq && pmDataBusy && !cacheHit)
            begin
                // clash stalls this fetch once, then it is cached for next time
                cacheData[cacheSlot]   <= pmInstr;
                cacheTagMem[cacheSlot] <= fetchTag;
                cacheValid[cacheSlot]  <= 1'b1;
            end
        end
    end

    // core timer: one-cycle irq on expiry, flag pin pulses when enabled
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timerCount  <= TIMER_RESET;
            timerReload <= TIMER_RESET;
            timerIrq    <= 1'b0;
            timer_expired_flag_pin <= 1'b0;
        end
        else
        begin
            timerIrq <= 1'b0;
            timer_expired_flag_pin <= 1'b0;
            if (timerLoad)
            begin
                timerReload <= timerPeriod;
                timerCount  <= timerPeriod;
            end
            else if (timerRun)
            begin
                if (timerCount == '0)
                begin
                    timerCount <= timerReload;
                    timerIrq   <= 1'b1;
                    timer_expired_flag_pin <= primary_mode_control[BIT_TMR_FLG];
                end
                else
                    timerCount <= timerCount - 32'h0000_0001;
            end
        end
    end
endmodule : sdc_core_datapath
`default_nettype wire

/* sdc_core_checker.sv */
// port checker for the dual-element simd core datapath top
// assumes a bind onto sdc_core_datapath, one core clock
`timescale 1ns/100ps
`default_nettype none
module sdc_core_checker
    import sdc_pkg::*;
(
    // clock and reset
    input wire logic                core_clk,
    input wire logic                rst_b,
    // mode and second element
    input wire logic                modeWrite,
    input wire logic [MODE_W-1:0]   modeData,
    input wire logic [MODE_W-1:0]   primary_mode_control,
    input wire logic [DATA_W-1:0]   secondMulResult,
    input wire logic                secondZero,
    // fetch and cache
    input wire logic                fetchReq,
    input wire logic [CACHE_AW-1:0] fetchTag,
    input wire logic                pmDataBusy,
    input wire logic                instrValid,
    input wire logic                cacheHit,
    // exchange
    input wire sdc_px_type          pxOp,
    input wire logic [BUS_W-1:0]    pmRdData,
    input wire logic [BUS_W-1:0]    dmWrData,
    input wire logic [BUS_W-1:0]    bus_exchange_register,
    // universal registers
    input wire logic                ubitEn,
    input wire sdc_ubit_type        ubitOp,
    input wire logic [WORD_W-1:0]   ubitMask,
    input wire logic [WORD_W-1:0]   ubitValue,
    input wire logic                ubitTest,
    // timer
    input wire logic                timerIrq,
    input wire logic                timer_expired_flag_pin
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_mode_load: assert property (modeWrite |=> primary_mode_control == $past(modeData))
        else $error("mode register missed its load");
    // mode held too, so a bank swap cannot move the result
    a_second_frozen: assert property (!primary_mode_control[BIT_PEY_EN] && !modeWrite
        |=> $stable(secondMulResult) && $stable(secondZero))
        else $error("disabled second element changed");
    a_hit_valid: assert property (fetchReq && cacheHit |=> instrValid)
        else $error("cache hit gave no instruction");
    a_free_fetch: assert property (fetchReq && !pmDataBusy |=> instrValid)
        else $error("free fetch gave no instruction");
    a_clash_miss: assert property (fetchReq && pmDataBusy && !cacheHit |=> !instrValid)
        else $error("clashing fetch delivered anyway");
    a_retry_hit: assert property (fetchReq && pmDataBusy && !cacheHit
        ##1 fetchReq && $stable(fetchTag) |-> cacheHit)
        else $error("clashing instruction was not cached");
    a_idle_quiet: assert property (!fetchReq |=> !instrValid)
        else $error("instruction without a fetch");
    a_px_pass: assert property (pxOp == PX_PM_TO_DM |=> bus_exchange_register ==
        $past(pmRdData) && dmWrData == $past(bus_exchange_register))
        else $error("exchange transfer wrong");
    a_ubit_test: assert property (ubitEn && ubitOp == UB_TST |=> ubitTest ==
        (($past(ubitValue) & $past(ubitMask)) == $past(ubitMask)))
        else $error("bit test result wrong");
    a_flag_irq: assert property (timer_expired_flag_pin |-> timerIrq)
        else $error("flag pin without timer expiry");

    c_hit: cover property (fetchReq && cacheHit);
    c_flag: cover property (timer_expired_flag_pin);
    c_px: cover property (pxOp == PX_PM_TO_DM);
endmodule : sdc_core_checker
`default_nettype wire

/* sdc_mem_model.sv */
// on-chip memory blocks seen over the pm and dm buses
// assumes same-cycle reads; bench preloads words before use
`timescale 1ns/100ps
`default_nettype none
module sdc_mem_model
    import sdc_pkg::*;
(
    // clock
    input wire logic                core_clk,
    // bench preload
    input wire logic                preEn,
    input wire logic [REG_AW-1:0]   preIdx,
    input wire logic [BUS_W-1:0]    preData,
    // core side
    input wire logic                dmLoad,
    input wire logic                pmLoad,
    input wire logic [REG_AW-1:0]   dmRegIdx,
    input wire logic [REG_AW-1:0]   pmRegIdx,
    input wire logic [CACHE_AW-1:0] fetchTag,
    output logic     [BUS_W-1:0]    dmRdData,
    output logic     [BUS_W-1:0]    pmRdData,
    output logic     [INSTR_W-1:0]  pmInstr,
    output logic                    pmDataBusy
);
    logic [BUS_W-1:0] mem [REG_CNT];
    logic [BUS_W-1:0] junk = 64'h1;
    always_ff @(posedge core_clk)
    begin
        junk <= {junk[62:0], ~junk[63]};
        if (preEn)
            mem[preIdx] <= preData;
    end
    // unread buses move every cycle so a stale word is never taken
    assign dmRdData = dmLoad ? mem[dmRegIdx] : junk;
    assign pmRdData = pmLoad ? ~mem[pmRegIdx] : ~junk;
    assign pmInstr = {fetchTag, 46'h1234_5678};
    assign pmDataBusy = pmLoad;
endmodule : sdc_mem_model
`default_nettype wire

/* simd_dual_element_core_datapath_tb.sv */
// self-checking bench for the dual-element simd core datapath
// assumes the memory model on the buses and the bound checker
`timescale 1ns/100ps
`default_nettype none
module simd_dual_element_core_datapath_tb
    import sdc_pkg::*;
;
    logic core_clk = 0, rst_b = 0, preEn = 0;
    logic modeWrite, dmLoad, pmLoad, fetchReq, ubitEn, timerLoad, timerRun;
    logic pmDataBusy, instrValid, cacheHit, ubitTest, timerIrq, timer_expired_flag_pin;
    logic firstZero, secondZero;
    logic [MODE_W-1:0] modeData, primary_mode_control;
    sdc_op_type aluOp, mulOp;
    sdc_fmt_type fmt;
    sdc_px_type pxOp;
    sdc_ubit_type ubitOp;
    logic [REG_AW-1:0] srcA, srcB, dstAlu, dstMul, dmRegIdx, pmRegIdx, preIdx, activeAddrBank;
    logic [BUS_W-1:0] dmRdData, pmRdData, dmWrData, pmWrData, bus_exchange_register, preData;
    logic [CACHE_AW-1:0] fetchTag;
    logic [INSTR_W-1:0] pmInstr, instrOut;
    logic [UNIV_AW-1:0] ubitSel;
    logic [WORD_W-1:0] ubitMask, ubitValue, v, a, b, p;
    logic [TIMER_W-1:0] timerPeriod;
    logic [DATA_W-1:0] firstMulResult, secondMulResult, held;
    logic [31:0] lf = 32'h7059;
    logic [63:0] memq [16];
    int failures = 0, n_checks = 0, cyc = 0, last;
    logic t;
    sdc_ubit_type ops [6] = '{UB_LOAD, UB_SET, UB_CLR, UB_TGL, UB_TST, UB_XOR};

    sdc_core_datapath dut_u (.*);
    sdc_mem_model mem_u (.*);

    always #25 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction : rnd

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    task automatic idle();
        {modeWrite, dmLoad, pmLoad, fetchReq, ubitEn, timerLoad, preEn} = '0;
        aluOp = OP_NOP;
        mulOp = OP_NOP;
        pxOp = PX_NONE;
    endtask : idle

    task automatic step();
        tick(1);
        idle();
    endtask : step

    task automatic setmode(input logic [MODE_W-1:0] m);
        modeWrite = 1;
        modeData = m;
        step();
    endtask : setmode

    // multifunction issue: add into reg 3, multiply into reg 4
    task automatic mfn(input logic [REG_AW-1:0] x, input logic [REG_AW-1:0] y);
        aluOp = OP_ADD;
        mulOp = OP_MUL;
        {srcA, srcB, dstAlu, dstMul} = {x, y, 4'h3, 4'h4};
        step();
    endtask : mfn

    task automatic rd3();
        pxOp = PX_FROM_REG;
        dmRegIdx = 3;
        step();
    endtask : rd3

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            failures++;
            wrap_up();
        end
    end

    initial
    begin
        idle();
        {srcA, srcB, dstAlu, dstMul, dmRegIdx, pmRegIdx, fetchTag, ubitSel} = '0;
        {modeData, ubitMask, timerPeriod, timerRun} = '0;
        fmt = FMT_FIXED;
        tick(10);
        rst_b = 1;
        chk(primary_mode_control, 0);
        chk(bus_exchange_register, 0);
        for (int i = 0; i < 16; i++)
        begin
            memq[i] = {rnd(), rnd()};
            {preEn, preIdx, preData} = {1'b1, 4'(i), memq[i]};
            step();
        end
        a = memq[1][31:0];
        b = memq[2][31:0];
        for (int k = 1; k < 3; k++)
        begin
            {dmLoad, dmRegIdx} = {1'b1, 4'(k)};
            step();
        end
        mfn(1, 2);
        p = a * b;
        chk(firstMulResult, 64'(p));
        chk(secondMulResult, 0);
        chk(dmWrData, memq[2][31:0]);
        rd3();
        chk(bus_exchange_register, {8'h0, a + b, 24'h0});
        $display("test single element done");
        setmode(5'h01);
        for (int k = 1; k < 3; k++)
        begin
            {dmLoad, dmRegIdx} = {1'b1, 4'(k)};
            step();
        end
        mfn(1, 2);
        p = memq[1][63:32] * memq[2][63:32];
        chk(secondMulResult, 64'(p));
        chk(dmWrData, memq[2]);
        held = secondMulResult;
        setmode(5'h00);
        mfn(2, 2);
        chk(secondMulResult, 64'(held));
        $display("test simd done");
        setmode(5'h04);
        chk(firstMulResult, 0);
        setmode(5'h02);
        rd3();
        chk(bus_exchange_register, 0);
        setmode(5'h00);
        rd3();
        chk(bus_exchange_register, {8'h0, b + b, 24'h0});
        $display("test context banks done");
        {pmLoad, pmRegIdx} = {1'b1, 4'h5};
        pxOp = PX_PM_TO_DM;
        tick(1);
        pmRegIdx = 6;
        step();
        chk(bus_exchange_register, ~memq[6]);
        chk(dmWrData, ~memq[5]);
        $display("test exchange done");
        for (int k = 0; k < 4; k++)
        begin
            // clash, retry, then a free fetch, then the free tag clashing
            {fetchReq, fetchTag, pmLoad} = {1'b1, 2'(k > 1 ? 2 : 1), k != 2};
            tick(1);
            chk(instrValid, k == 1 || k == 2);
            if (k == 1)
                chk(instrOut, 64'({2'd1, 46'h1234_5678}));
        end
        idle();
        $display("test cache done");
        for (int s = 0; s < 4; s++)
        begin
            ubitSel = 2'(s);
            foreach (ops[j])
            begin
                ubitMask = rnd();
                if (ops[j] == UB_TST)
                    ubitMask = ubitMask & v;
                if (ops[j] == UB_XOR && s[0])
                    ubitMask = v;
                ubitEn = 1;
                ubitOp = ops[j];
                step();
                case (ops[j])
                    UB_LOAD: v = ubitMask;
                    UB_SET: v = v | ubitMask;
                    UB_CLR: v = v & ~ubitMask;
                    UB_TGL: v = v ^ ubitMask;
                    UB_TST: t = (v & ubitMask) == ubitMask;
                    default: t = v == ubitMask;
                endcase
                chk(ubitValue, 64'(v));
                if (j > 3)
                    chk(ubitTest, t);
            end
        end
        $display("test universal done");
        for (int ph = 0; ph < 2; ph++)
        begin
            setmode(ph ? 5'h00 : 5'h10);
            {timerLoad, timerPeriod, timerRun} = {1'b1, 32'h4, 1'b1};
            step();
            last = -1;
            for (int c = 0; c < 30; c++)
            begin
                chk(timer_expired_flag_pin, timerIrq && !ph);
                if (timerIrq && last >= 0)
                    chk(c - last, 5);
                if (timerIrq)
                    last = c;
                tick(1);
            end
            chk(last > 20, 1);
        end
        $display("test timer done");
        wrap_up();
    end
endmodule : simd_dual_element_core_datapath_tb

bind sdc_core_datapath sdc_core_checker chk_u (.core_clk, .rst_b, .modeWrite, .modeData,
    .primary_mode_control, .secondMulResult, .secondZero, .fetchReq, .fetchTag,
    .pmDataBusy, .instrValid, .cacheHit, .pxOp, .pmRdData, .dmWrData,
    .bus_exchange_register, .ubitEn, .ubitOp, .ubitMask, .ubitValue, .ubitTest,
    .timerIrq, .timer_expired_flag_pin);
`default_nettype wire
